// ### src/regfile_pkg.sv
// constants, types and encodings shared by the banked register file
// assumes: a single 25 MHz core clock domain
package regfile_pkg;

   localparam int unsigned NUM_GPR  = 31;
   localparam int unsigned NUM_SR   = 6;
   localparam int unsigned NUM_PHYS = 37;
   localparam int unsigned DW       = 32;

   // mode field encodings (five bits)
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1b;
   localparam logic [4:0] MODE_SYS = 5'h1f;

   // status word bit positions
   localparam int unsigned BIT_N    = 31;
   localparam int unsigned BIT_Z    = 30;
   localparam int unsigned BIT_C    = 29;
   localparam int unsigned BIT_V    = 28;
   localparam int unsigned BIT_Q    = 27;
   localparam int unsigned BIT_J    = 24;
   localparam int unsigned BIT_I    = 7;
   localparam int unsigned BIT_F    = 6;
   localparam int unsigned BIT_T    = 5;
   localparam int unsigned MODE_LSB = 0;

   // register indices with fixed roles
   localparam logic [3:0] IDX_SP = 4'hd;
   localparam logic [3:0] IDX_LR = 4'he;
   localparam logic [3:0] IDX_PC = 4'hf;
   localparam logic [3:0] IDX_FIQ_LO = 4'h8;

   // physical slots: 0..15 user, 16..22 fast r8..r14, then 13/14 pairs
   localparam logic [4:0] SLOT_FIQ = 5'h10;
   localparam logic [4:0] SLOT_SVC = 5'h17;
   localparam logic [4:0] SLOT_ABT = 5'h19;
   localparam logic [4:0] SLOT_UND = 5'h1b;
   localparam logic [4:0] SLOT_IRQ = 5'h1d;

   // saved word slots
   localparam logic [2:0] SAV_SVC = 3'h0;
   localparam logic [2:0] SAV_ABT = 3'h1;
   localparam logic [2:0] SAV_UND = 3'h2;
   localparam logic [2:0] SAV_IRQ = 3'h3;
   localparam logic [2:0] SAV_FIQ = 3'h4;
   localparam logic [2:0] SAV_NONE = 3'h7;

   // status word after reset: supervisor, both interrupts masked
   localparam logic [31:0] CSW_RESET = 32'h000000d3;

   // instruction states derived from J and T
   typedef enum logic [2:0] {
      ST_FULL    = 3'b001,
      ST_COMPACT = 3'b010,
      ST_BYTE    = 3'b100
   } istate_e;

   // exception kinds (one-hot)
   typedef enum logic [5:0] {
      EXC_NONE  = 6'b000000,
      EXC_RESET = 6'b000001,
      EXC_FIQ   = 6'b000010,
      EXC_IRQ   = 6'b000100,
      EXC_ABT   = 6'b001000,
      EXC_UND   = 6'b010000,
      EXC_SWI   = 6'b100000
   } exc_e;

   typedef struct packed {
      logic       en;
      logic [3:0] idx;
      logic [31:0] data;
   } wr_s;

   typedef struct packed {
      logic        n;
      logic        z;
      logic        c;
      logic        v;
      logic        q_set;
   } flags_s;

   // map an architectural index to a physical slot under a mode
   function automatic logic [4:0] phys_slot(input logic [4:0] mode, input logic [3:0] idx);
      logic [4:0] base;
      base = 5'h00;
      if (mode == MODE_FIQ && idx >= IDX_FIQ_LO && idx <= IDX_LR) begin
         return SLOT_FIQ + {1'b0, idx - IDX_FIQ_LO};
      end
      if (idx == IDX_SP || idx == IDX_LR) begin
         case (mode)
            MODE_SVC: base = SLOT_SVC;
            MODE_ABT: base = SLOT_ABT;
            MODE_UND: base = SLOT_UND;
            MODE_IRQ: base = SLOT_IRQ;
            default:  base = 5'h00;
         endcase
         if (base != 5'h00) begin
            return base + {4'h0, idx[0] ^ 1'b1};
         end
      end
      return {1'b0, idx};
   endfunction : phys_slot

   // saved word owned by a mode, none for user and system
   function automatic logic [2:0] saved_slot(input logic [4:0] mode);
      case (mode)
         MODE_SVC: return SAV_SVC;
         MODE_ABT: return SAV_ABT;
         MODE_UND: return SAV_UND;
         MODE_IRQ: return SAV_IRQ;
         MODE_FIQ: return SAV_FIQ;
         default:  return SAV_NONE;
      endcase
   endfunction : saved_slot

   function automatic logic mode_valid(input logic [4:0] mode);
      return mode == MODE_USR || mode == MODE_FIQ || mode == MODE_IRQ ||
             mode == MODE_SVC || mode == MODE_ABT || mode == MODE_UND ||
             mode == MODE_SYS;
   endfunction : mode_valid

endpackage : regfile_pkg

// ### src/gpr_mem.sv
// 31-word general register store, two registered read ports, two write ports
// assumes: slot numbers 0..30 supplied by the mode mapper
`timescale 1ns/1ps
`default_nettype none
module gpr_mem
   import regfile_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // write port
   input  wire logic        we_in,
   input  wire logic [4:0]  wslot_in,
   input  wire logic [31:0] wdata_in,
   // second write port (link capture)
   input  wire logic        we2_in,
   input  wire logic [4:0]  wslot2_in,
   input  wire logic [31:0] wdata2_in,
   // read ports
   input  wire logic [4:0]  raddr_a_in,
   input  wire logic [4:0]  raddr_b_in,
   output logic      [31:0] rdata_a_out,
   output logic      [31:0] rdata_b_out
);
   logic [31:0] mem_q [NUM_GPR];

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NUM_GPR; i++) mem_q[i] <= 32'h00000000;
      end else begin
         if (we_in && wslot_in < 5'(NUM_GPR)) mem_q[wslot_in] <= wdata_in;
         if (we2_in && wslot2_in < 5'(NUM_GPR)) mem_q[wslot2_in] <= wdata2_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_a_out <= 32'h00000000;
         rdata_b_out <= 32'h00000000;
      end else begin
         rdata_a_out <= (raddr_a_in < 5'(NUM_GPR)) ? mem_q[raddr_a_in] : 32'h00000000;
         rdata_b_out <= (raddr_b_in < 5'(NUM_GPR)) ? mem_q[raddr_b_in] : 32'h00000000;
      end
   end
endmodule : gpr_mem
`default_nettype wire

// ### src/status_words.sv
// five saved status words, one per exception mode
// assumes: slot chosen by saved_slot(); slot 7 means none
`timescale 1ns/1ps
`default_nettype none
module status_words
   import regfile_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // write
   input  wire logic        we_in,
   input  wire logic [2:0]  wslot_in,
   input  wire logic [31:0] wdata_in,
   // read
   input  wire logic [2:0]  rslot_in,
   output logic      [31:0] rdata_out
);
   logic [31:0] sav_q [5];

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < 5; i++) sav_q[i] <= 32'h00000000;
      end else if (we_in && wslot_in < 3'h5) begin
         sav_q[wslot_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) rdata_out <= 32'h00000000;
      // write-through: a word saved this cycle shows on the next
      else if (we_in && wslot_in == rslot_in && wslot_in < 3'h5) rdata_out <= wdata_in;
      else rdata_out <= (rslot_in < 3'h5) ? sav_q[rslot_in] : 32'h00000000;
   end
endmodule : status_words
`default_nettype wire

// ### src/banked_mode_register_file.sv
// banked register file with current and saved status words
// assumes: pipeline presents one request per cycle; reads return a cycle later
`timescale 1ns/1ps
`default_nettype none
module banked_mode_register_file
   import regfile_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // register read requests
   input  wire logic [3:0]  ridx_a_in,
   input  wire logic [3:0]  ridx_b_in,
   // register write and flag update
   input  wire wr_s         wr_in,
   input  wire logic        flags_we_in,
   input  wire flags_s      flags_in,
   // link branch with its return address
   input  wire logic        link_branch_in,
   input  wire logic [31:0] link_addr_in,
   // status write instruction
   input  wire logic        csw_we_in,
   input  wire logic [31:0] csw_wdata_in,
   input  wire logic        ssw_we_in,
   input  wire logic [31:0] ssw_wdata_in,
   // exceptions
   input  wire logic        fiq_req_in,
   input  wire logic        irq_req_in,
   input  wire logic        abort_in,
   input  wire logic        undef_in,
   input  wire logic        swi_in,
   input  wire logic        reset_exc_in,
   input  wire logic [31:0] ret_addr_in,
   input  wire logic [31:0] vector_in,
   input  wire logic [3:0]  cond_in,
   // outputs
   output logic      [31:0] rdata_a_out,
   output logic      [31:0] rdata_b_out,
   output logic      [31:0] pc_out,
   output logic      [31:0] csw_out,
   output logic      [31:0] ssw_out,
   output logic             cond_pass_out,
   output logic             idx_fault_out,
   output logic             exc_taken_out,
   output istate_e          istate_out
);
   logic [31:0] csw_q, csw_d;
   logic [31:0] pc_q;
   logic [31:0] mem_a, mem_b;
   logic [31:0] ssw_rd;
   logic [4:0]  mode;
   exc_e        exc;
   logic [4:0]  new_mode;
   logic        allowed_a, allowed_b, allowed_w;
   logic        rd_pc_a_q, rd_pc_b_q;
   logic        mem_we, lr_we;
   logic [4:0]  mem_wslot, lr_slot;
   logic [31:0] lr_data;

   assign mode = csw_q[4:0];

   // compact state hides 8..12
   function automatic logic idx_ok(input logic [31:0] csw, input logic [3:0] idx);
      if (csw[BIT_T] && !csw[BIT_J])
         return idx <= 4'h7 || idx == IDX_SP || idx == IDX_LR || idx == IDX_PC;
      return 1'b1;
   endfunction : idx_ok

   // N Z C V only; saturation flag never consulted
   function automatic logic cond_eval(input logic [31:0] csw, input logic [3:0] c);
      logic n, z, cf, v;
      n = csw[BIT_N];
      z = csw[BIT_Z];
      cf = csw[BIT_C];
      v = csw[BIT_V];
      case (c)
         4'h0: return z;
         4'h1: return !z;
         4'h2: return cf;
         4'h3: return !cf;
         4'h4: return n;
         4'h5: return !n;
         4'h6: return v;
         4'h7: return !v;
         4'h8: return cf && !z;
         4'h9: return !cf || z;
         4'ha: return n == v;
         4'hb: return n != v;
         4'hc: return !z && (n == v);
         4'hd: return z || (n != v);
         default: return 1'b1;
      endcase
   endfunction : cond_eval

   // priority: reset, abort, fiq, irq, undef, swi; masks gate interrupts
   always_comb begin
      if (reset_exc_in) exc = EXC_RESET;
      else if (abort_in) exc = EXC_ABT;
      else if (fiq_req_in && !csw_q[BIT_F]) exc = EXC_FIQ;
      else if (irq_req_in && !csw_q[BIT_I]) exc = EXC_IRQ;
      else if (undef_in) exc = EXC_UND;
      else if (swi_in) exc = EXC_SWI;
      else exc = EXC_NONE;
   end

   always_comb begin
      case (exc)
         EXC_FIQ:   new_mode = MODE_FIQ;
         EXC_IRQ:   new_mode = MODE_IRQ;
         EXC_ABT:   new_mode = MODE_ABT;
         EXC_UND:   new_mode = MODE_UND;
         EXC_RESET: new_mode = MODE_SVC;
         EXC_SWI:   new_mode = MODE_SVC;
         default:   new_mode = mode;
      endcase
   end

   assign allowed_a = idx_ok(csw_q, ridx_a_in);
   assign allowed_b = idx_ok(csw_q, ridx_b_in);
   assign allowed_w = idx_ok(csw_q, wr_in.idx);

   // general write path; r15 goes to the shared counter instead
   always_comb begin
      mem_we = wr_in.en && allowed_w && wr_in.idx != IDX_PC && exc == EXC_NONE;
      mem_wslot = phys_slot(mode, wr_in.idx);
   end

   // link capture: entry to any exception but reset, into the new mode, or link branch in current
   always_comb begin
      lr_we = 1'b0;
      lr_slot = phys_slot(mode, IDX_LR);
      lr_data = link_addr_in;
      if (exc != EXC_NONE && exc != EXC_RESET) begin
         lr_we = 1'b1;
         lr_slot = phys_slot(new_mode, IDX_LR);
         lr_data = ret_addr_in;
      end else if (exc == EXC_NONE && link_branch_in) begin
         lr_we = 1'b1;
      end
   end

   gpr_mem u_gpr (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .we_in       (mem_we),
      .wslot_in    (mem_wslot),
      .wdata_in    (wr_in.data),
      .we2_in      (lr_we),
      .wslot2_in   (lr_slot),
      .wdata2_in   (lr_data),
      .raddr_a_in  (phys_slot(mode, ridx_a_in)),
      .raddr_b_in  (phys_slot(mode, ridx_b_in)),
      .rdata_a_out (mem_a),
      .rdata_b_out (mem_b)
   );

   status_words u_sav (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .we_in     ((exc != EXC_NONE && exc != EXC_RESET) || (ssw_we_in && exc == EXC_NONE)),
      .wslot_in  (exc != EXC_NONE ? saved_slot(new_mode) : saved_slot(mode)),
      .wdata_in  (exc != EXC_NONE ? csw_q : ssw_wdata_in),
      .rslot_in  (saved_slot(exc != EXC_NONE ? new_mode : csw_d[4:0])),
      .rdata_out (ssw_rd)
   );

   // current status word next value
   always_comb begin
      csw_d = csw_q;
      if (exc != EXC_NONE) begin
         if (exc == EXC_RESET) csw_d = CSW_RESET;
         csw_d[4:0] = new_mode;
         csw_d[BIT_J] = 1'b0;
         csw_d[BIT_T] = 1'b0;
         csw_d[BIT_I] = 1'b1;
         if (exc == EXC_FIQ || exc == EXC_RESET) csw_d[BIT_F] = 1'b1;
      end else begin
         if (flags_we_in) begin
            csw_d[BIT_N] = flags_in.n;
            csw_d[BIT_Z] = flags_in.z;
            csw_d[BIT_C] = flags_in.c;
            csw_d[BIT_V] = flags_in.v;
         end
         if (csw_we_in) begin
            csw_d = csw_wdata_in;
            if (!mode_valid(csw_wdata_in[4:0])) csw_d[4:0] = csw_q[4:0];
            if (mode == MODE_USR) csw_d[7:0] = csw_q[7:0];
         end
         if (flags_we_in && flags_in.q_set) csw_d[BIT_Q] = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) csw_q <= CSW_RESET;
      else csw_q <= csw_d;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) pc_q <= 32'h00000000;
      else if (exc != EXC_NONE) pc_q <= vector_in;
      else if (wr_in.en && wr_in.idx == IDX_PC) pc_q <= wr_in.data;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_pc_a_q <= 1'b0;
         rd_pc_b_q <= 1'b0;
         idx_fault_out <= 1'b0;
         cond_pass_out <= 1'b0;
         exc_taken_out <= 1'b0;
      end else begin
         rd_pc_a_q <= ridx_a_in == IDX_PC;
         rd_pc_b_q <= ridx_b_in == IDX_PC;
         idx_fault_out <= !allowed_a || !allowed_b || (wr_in.en && !allowed_w);
         cond_pass_out <= cond_eval(csw_q, cond_in);
         exc_taken_out <= exc != EXC_NONE;
      end
   end

   always_comb begin
      rdata_a_out = rd_pc_a_q ? pc_q : mem_a;
      rdata_b_out = rd_pc_b_q ? pc_q : mem_b;
      pc_out = pc_q;
      csw_out = csw_q;
      ssw_out = ssw_rd;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) istate_out <= ST_FULL;
      else if (csw_d[BIT_J]) istate_out <= ST_BYTE;
      else if (csw_d[BIT_T]) istate_out <= ST_COMPACT;
      else istate_out <= ST_FULL;
   end

   // assertions
   property p_exc_mode;
      @(posedge clk_in) disable iff (!rstn_in)
      (abort_in && !reset_exc_in) |=> csw_q[4:0] == MODE_ABT && exc_taken_out;
   endproperty
   a_exc_mode: assert property (p_exc_mode) else $error("abort did not enter abort mode");

   property p_irq_leaves_byte;
      @(posedge clk_in) disable iff (!rstn_in)
      (irq_req_in && !csw_q[BIT_I] && csw_q[BIT_J]) |=> !csw_q[BIT_J] && !csw_q[BIT_T];
   endproperty
   a_irq_leaves_byte: assert property (p_irq_leaves_byte) else $error("interrupt kept bytecode");

   property p_irq_masked;
      @(posedge clk_in) disable iff (!rstn_in)
      (irq_req_in && csw_q[BIT_I] && !reset_exc_in && !abort_in && !fiq_req_in
       && !undef_in && !swi_in) |=> !exc_taken_out;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt taken");

   property p_sat_sticky;
      @(posedge clk_in) disable iff (!rstn_in)
      (csw_q[BIT_Q] && !csw_we_in && exc != EXC_RESET) |=> csw_q[BIT_Q];
   endproperty
   a_sat_sticky: assert property (p_sat_sticky) else $error("saturation flag dropped");

   property p_save_word;
      @(posedge clk_in) disable iff (!rstn_in)
      (undef_in && !reset_exc_in && !abort_in && !(fiq_req_in && !csw_q[BIT_F])
       && !(irq_req_in && !csw_q[BIT_I])) |=> ssw_out == $past(csw_q);
   endproperty
   a_save_word: assert property (p_save_word) else $error("saved word wrong");

   property p_mode_valid;
      @(posedge clk_in) disable iff (!rstn_in)
      1'b1 |-> mode_valid(csw_q[4:0]);
   endproperty
   a_mode_valid: assert property (p_mode_valid) else $error("illegal mode");

   property p_pc_write;
      @(posedge clk_in) disable iff (!rstn_in)
      (wr_in.en && wr_in.idx == IDX_PC && !exc_taken_out && !reset_exc_in && !abort_in
       && !undef_in && !swi_in && !fiq_req_in && !irq_req_in) |=> pc_q == $past(wr_in.data);
   endproperty
   a_pc_write: assert property (p_pc_write) else $error("counter not written");

   property p_compact_fault;
      @(posedge clk_in) disable iff (!rstn_in)
      (csw_q[BIT_T] && !csw_q[BIT_J] && ridx_a_in == 4'h9) |=> idx_fault_out;
   endproperty
   a_compact_fault: assert property (p_compact_fault) else $error("hidden index allowed");
endmodule : banked_mode_register_file
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the banked register file, queue of expected notes
// assumes: design package and modules compiled first; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import regfile_pkg::*;
   typedef struct {int cyc; int sel; logic [31:0] exp; logic [31:0] msk;} note_s;
   localparam int W = 1, FL = 2, LK = 4, CS = 8, SS = 16, FQ = 32;
   localparam int IQ = 64, AB = 128, UN = 256, SW = 512, RS = 1024;
   logic        clk_in = 1'h0;
   logic        rstn_in = 1'h0;
   logic [3:0]  ridx_a_in = 4'h0, ridx_b_in = 4'h0, cond_in = 4'h0;
   wr_s         wr_in = '0;
   flags_s      flags_in = '0;
   logic        flags_we_in = 1'h0, link_branch_in = 1'h0, csw_we_in = 1'h0, ssw_we_in = 1'h0;
   logic        fiq_req_in = 1'h0, irq_req_in = 1'h0, abort_in = 1'h0;
   logic        undef_in = 1'h0, swi_in = 1'h0, reset_exc_in = 1'h0;
   logic [31:0] link_addr_in = '0, csw_wdata_in = '0, ssw_wdata_in = '0;
   logic [31:0] ret_addr_in = '0, vector_in = '0;
   logic [31:0] rdata_a_out, rdata_b_out, pc_out, csw_out, ssw_out;
   logic        cond_pass_out, idx_fault_out, exc_taken_out;
   istate_e     istate_out;
   int          cyc = 0, err_total = 0, total_checks = 0;
   note_s       notes[$];
   note_s       cur;
   logic [31:0] bank [31];
   logic [4:0]  mode;
   logic [4:0]  pm [6] = '{MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND, MODE_SYS};
   logic [31:0] pre [6] = '{32'hdf, 32'hdf, 32'hdf, 32'h9f, 32'h5f, 32'h1f};
   logic [4:0]  em [6] = '{MODE_ABT, MODE_UND, MODE_SVC, MODE_FIQ, MODE_IRQ, MODE_ABT};
   int          ex [6] = '{AB, UN, SW, FQ, IQ, AB + IQ};
   logic [3:0]  cc [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hf};
   logic        cp [7] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};

   banked_mode_register_file i_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .ridx_a_in(ridx_a_in), .ridx_b_in(ridx_b_in),
      .wr_in(wr_in), .flags_we_in(flags_we_in), .flags_in(flags_in),
      .link_branch_in(link_branch_in), .link_addr_in(link_addr_in),
      .csw_we_in(csw_we_in), .csw_wdata_in(csw_wdata_in), .ssw_we_in(ssw_we_in),
      .ssw_wdata_in(ssw_wdata_in), .fiq_req_in(fiq_req_in), .irq_req_in(irq_req_in),
      .abort_in(abort_in), .undef_in(undef_in), .swi_in(swi_in),
      .reset_exc_in(reset_exc_in), .ret_addr_in(ret_addr_in), .vector_in(vector_in),
      .cond_in(cond_in), .rdata_a_out(rdata_a_out), .rdata_b_out(rdata_b_out),
      .pc_out(pc_out), .csw_out(csw_out), .ssw_out(ssw_out),
      .cond_pass_out(cond_pass_out), .idx_fault_out(idx_fault_out),
      .exc_taken_out(exc_taken_out), .istate_out(istate_out)
   );

   always #20 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   // own bank layout, independent of the design's mapping
   function automatic int slot(logic [4:0] m, logic [3:0] i);
      int b;
      b = (m == MODE_SVC) ? 23 : (m == MODE_ABT) ? 25 : 0;
      b = (m == MODE_UND) ? 27 : (m == MODE_IRQ) ? 29 : b;
      if (m == MODE_FIQ && i >= 4'h8 && i <= 4'he) return 8 + int'(i);
      if (b != 0 && i >= 4'hd && i <= 4'he) return b + int'(i) - 13;
      return int'(i);
   endfunction : slot

   function automatic logic [31:0] seen(int sel);
      case (sel)
         0: return rdata_a_out;
         1: return rdata_b_out;
         2: return pc_out;
         3: return csw_out;
         4: return ssw_out;
         5: return {31'h0, cond_pass_out};
         6: return {31'h0, idx_fault_out};
         7: return {31'h0, exc_taken_out};
         default: return {29'h0, istate_out};
      endcase
   endfunction : seen

   task automatic check(logic [31:0] got, logic [31:0] exp, int sel);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: output %0d saw %h expected %h", $time, sel, got, exp);
      end
   endtask : check

   task automatic expect_at(int sel, logic [31:0] exp, logic [31:0] msk = 32'hffffffff);
      notes.push_back('{cyc + 1, sel, exp, msk});
   endtask : expect_at

   // each pulse input assigned once per cycle
   task automatic go(int p);
      @(posedge clk_in);
      #1;
      wr_in.en = p[0];
      flags_we_in = p[1];
      link_branch_in = p[2];
      csw_we_in = p[3];
      ssw_we_in = p[4];
      fiq_req_in = p[5];
      irq_req_in = p[6];
      abort_in = p[7];
      undef_in = p[8];
      swi_in = p[9];
      reset_exc_in = p[10];
   endtask : go

   task automatic setcsw(logic [31:0] v);
      go(CS);
      csw_wdata_in = v;
      mode = v[4:0];
      expect_at(3, v);
   endtask : setcsw

   task automatic wr(logic [3:0] i, logic [31:0] d);
      go(W);
      wr_in.idx = i;
      wr_in.data = d;
      bank[slot(mode, i)] = d;
      if (i == 4'hf) expect_at(2, d);
   endtask : wr

   task automatic rd(logic [3:0] i);
      go(0);
      ridx_a_in = i;
      ridx_b_in = 4'($urandom_range(15, 0));
      expect_at(0, bank[slot(mode, i)]);
      expect_at(1, bank[slot(mode, ridx_b_in)]);
   endtask : rd

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // expected notes compared when their result cycle arrives
   always @(negedge clk_in) begin
      while (notes.size() > 0 && notes[0].cyc <= cyc) begin
         cur = notes.pop_front();
         check(seen(cur.sel) & cur.msk, cur.exp & cur.msk, cur.sel);
      end
   end

   initial begin
      #80000;
      err_total++;
      complete_run();
   end

   initial begin
      void'($urandom(98346));
      foreach (bank[k]) bank[k] = 32'h0;
      repeat (3) @(posedge clk_in);
      #1;
      rstn_in = 1'h1;
      mode = MODE_SVC;
      go(0);
      expect_at(3, CSW_RESET);
      expect_at(8, {29'h0, ST_FULL});
      // random banked traffic, access right after each mode change
      for (int k = 0; k < 40; k++) begin
         setcsw({24'h0, 3'h6, pm[$urandom_range(5, 0)]});
         wr(4'($urandom_range(15, 0)), $urandom());
         rd(wr_in.idx);
      end
      // compact state: upper registers refused
      setcsw(32'h000000ff);
      go(W);
      wr_in.idx = 4'h8;
      wr_in.data = $urandom();
      ridx_a_in = 4'h9;
      expect_at(6, 32'h1);
      expect_at(8, {29'h0, ST_COMPACT});
      setcsw(32'h0100005f);
      go(0);
      expect_at(8, {29'h0, ST_BYTE});
      // interrupt out of bytecode state
      go(IQ);
      ret_addr_in = $urandom();
      vector_in = $urandom();
      mode = MODE_IRQ;
      bank[slot(mode, 4'he)] = ret_addr_in;
      bank[15] = vector_in;
      expect_at(3, 32'h000000d2);
      expect_at(4, 32'h0100005f);
      expect_at(2, vector_in);
      go(0);
      expect_at(8, {29'h0, ST_FULL});
      rd(4'he);
      rd(4'h8);
      go(LK);
      link_addr_in = $urandom();
      bank[slot(mode, 4'he)] = link_addr_in;
      rd(4'he);
      go(SS);
      ssw_wdata_in = 32'h000000df;
      expect_at(4, 32'h000000df);
      go(IQ);
      expect_at(7, 32'h0);
      expect_at(3, 32'h000000d2);
      // every exception kind except reset, and abort beating interrupt
      for (int e = 0; e < 6; e++) begin
         setcsw(pre[e]);
         go(ex[e]);
         ret_addr_in = $urandom();
         vector_in = $urandom();
         mode = em[e];
         bank[slot(mode, 4'he)] = ret_addr_in;
         bank[15] = vector_in;
         expect_at(3, {24'h0, 3'h4, em[e]}, 32'h010000bf);
         expect_at(4, pre[e]);
         expect_at(2, vector_in);
         expect_at(7, 32'h1);
         rd(4'he);
         expect_at(7, 32'h0);
      end
      // flags, sticky saturation, conditions
      go(FL);
      flags_in = '{n: 1'h1, z: 1'h1, c: 1'h0, v: 1'h1, q_set: 1'h1};
      expect_at(3, 32'hd8000000, 32'hf8000000);
      go(FL);
      flags_in = '{n: 1'h0, z: 1'h0, c: 1'h1, v: 1'h0, q_set: 1'h0};
      expect_at(3, 32'h28000000, 32'hf8000000);
      for (int k = 0; k < 7; k++) begin
         go(0);
         cond_in = cc[k];
         expect_at(5, {31'h0, cp[k]});
      end
      setcsw(32'h0000001f);
      // user mode cannot leave, has no saved word
      setcsw(32'h000000d0);
      go(CS);
      csw_wdata_in = 32'h000000d3;
      expect_at(3, 32'h000000d0, 32'h000000ff);
      expect_at(4, 32'h0);
      rd(4'hd);
      // reset exception: supervisor, no link save
      go(RS);
      vector_in = $urandom();
      bank[15] = vector_in;
      mode = MODE_SVC;
      expect_at(3, CSW_RESET);
      expect_at(2, vector_in);
      expect_at(7, 32'h1);
      rd(4'he);
      go(0);
      go(0);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
